/* hdl/gpg_top.sv */
// Top of the second general-purpose pin group: register port, four lines.
// Assumes a master that holds strobes one cycle and never overlaps them;
// the pins are resolved by the board from pin_out and pin_oe.
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Direction bit 0 input, 1 driven output
// - Input line reads back sampled pin level
// - Writes to input line never drive pin
// - Output line drives last written level
module gpg_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pins
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe
);
    function automatic logic reg_hit(input logic [15:0] addr);
        reg_hit = (addr == gpg_pkg::PIN_GROUP1_DIR_LEVEL_ADDR);
    endfunction

    logic wr_hit;
    logic rd_hit;
    logic [3:0] pin_sync;
    logic [3:0] rd_level;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    assign wr_hit = reg_wr & reg_hit(reg_addr);
    assign rd_hit = reg_rd & reg_hit(reg_addr);

    gpg_sync u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // Line g sits in direction bit 4+g and level bit g
    genvar g;
    generate
        for (g = 0; g < gpg_pkg::LINES; g++) begin : g_line
            gpg_line u_line (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .wr_hit(wr_hit),
                .wr_dir(reg_wdata[gpg_pkg::DIR_LSB + g]),
                .wr_level(reg_wdata[gpg_pkg::LEVEL_LSB + g]),
                .pin_sync(pin_sync[g]),
                .pin_out(pin_out[g]),
                .pin_oe(pin_oe[g]),
                .rd_level(rd_level[g])
            );
        end
    endgenerate

    // Read path: direction bits back as written, level bits per line
    always_comb begin
        if (rd_hit) begin
            rdata_d = {pin_oe, rd_level};
        end else if (reg_rd) begin
            rdata_d = gpg_pkg::UNMAPPED_READ;
        end else begin
            rdata_d = rdata_q;
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= gpg_pkg::UNMAPPED_READ;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= gpg_pkg::UNMAPPED_READ;
        end
    end

    assign reg_rdata = rdata_q;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_dir_write_oe: assert property (
        wr_hit |=> pin_oe == $past(reg_wdata[7:4])
    ) else $error("pin enable does not follow written direction");

    a_input_read: assert property (
        rd_hit |=> ((reg_rdata[3:0] ^ $past(pin_sync)) & ~$past(pin_oe))
            == 4'h0
    ) else $error("input line read does not show pin level");

    a_input_no_drive: assert property (
        (wr_hit && reg_wdata[7:4] == 4'h0) |=> pin_oe == 4'h0 [*1]
    ) else $error("input line driven after write");

    a_input_stays: assert property (
        (!wr_hit && pin_oe == 4'h0) |=> pin_oe == 4'h0
    ) else $error("input line started driving without a write");

    a_output_drive: assert property (
        wr_hit |=> pin_out == $past(reg_wdata[3:0])
    ) else $error("output level differs from written value");

    a_level_held: assert property (
        !wr_hit |=> $stable(pin_out) && $stable(pin_oe)
    ) else $error("pin state changed without a write");

    a_output_read: assert property (
        rd_hit |=> ((reg_rdata[3:0] ^ $past(pin_out)) & $past(pin_oe))
            == 4'h0
    ) else $error("output line read differs from driven level");

    a_dir_read: assert property (
        rd_hit |=> reg_rdata[7:4] == $past(pin_oe)
    ) else $error("direction read back wrong");

    a_unmapped_read: assert property (
        (reg_rd && !rd_hit) |=> reg_rdata == 8'h00
    ) else $error("unmapped read not zero");

    a_idle_rdata: assert property (
        !reg_rd |=> reg_rdata == 8'h00
    ) else $error("read data outside the answer cycle");

    c_make_output: cover property (
        wr_hit && reg_wdata[7:4] != 4'h0 ##1 pin_oe != 4'h0
    );

    c_read_input: cover property (
        pin_oe == 4'h0 && rd_hit ##1 reg_rdata[3:0] != 4'h0
    );

    c_back_to_input: cover property (
        pin_oe == 4'hf ##1 wr_hit && reg_wdata[7:4] == 4'h0
    );

    c_write_then_read: cover property (
        wr_hit ##1 rd_hit
    );
endmodule // gpg_top
`default_nettype wire

/* hdl/gpg_pkg.sv */
// Constants for the second group of four general-purpose pins.
// Assumes one 20 MHz clock and a plain address/strobe register port.
package gpg_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int LINES = 4;
    localparam int SYNC_STAGES = 2;
    // Register offset as printed; the port carries it unchanged
    localparam logic [15:0] PIN_GROUP1_DIR_LEVEL_ADDR = 16'h4102;
    // Field positions: direction in the upper nibble, level in the lower
    localparam int DIR_LSB = 4;
    localparam int LEVEL_LSB = 0;
    // Reset values: every line an input, written levels low
    localparam logic [3:0] DIR_RESET = 4'h0;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam int CLK_PERIOD_NS = 50;
endpackage : gpg_pkg

/* hdl/gpg_sync.sv */
// Two-flip-flop synchroniser for the four pin inputs.
// Assumes pins change with no relation to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module gpg_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Asynchronous pins in, synchronised levels out
    input wire logic [3:0] async_in,
    output logic [3:0] sync_out
);
    genvar g;
    generate
        for (g = 0; g < gpg_pkg::LINES; g++) begin : g_line
            logic [1:0] stage_q;
            // Only the second stage leaves this module
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    stage_q <= gpg_pkg::SYNC_RESET;
                end else begin
                    stage_q <= {stage_q[0], async_in[g]};
                end
            end
            assign sync_out[g] = stage_q[1];
        end
    endgenerate
endmodule // gpg_sync
`default_nettype wire

/* hdl/gpg_line.sv */
// One general-purpose line: direction flop, written level, pin drive.
// Assumes the write strobe is already decoded for this register.
`timescale 1ns/10ps
`default_nettype none
module gpg_line (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Decoded register write
    input wire logic wr_hit,
    input wire logic wr_dir,
    input wire logic wr_level,
    // Synchronised pin level
    input wire logic pin_sync,
    // Pin drive
    output logic pin_out,
    output logic pin_oe,
    // Value this line shows in its level bit on a read
    output logic rd_level
);
    logic dir_q;
    logic level_q;

    // Direction: 0 input, 1 output driven by us
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dir_q <= 1'b0;
        end else if (wr_hit) begin
            dir_q <= wr_dir;
        end
    end

    // Written level is kept even while the line is an input, so that
    // turning it to output later drives the last value software chose
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_q <= 1'b0;
        end else if (wr_hit) begin
            level_q <= wr_level;
        end
    end

    assign pin_out = level_q;
    assign pin_oe = dir_q;
    assign rd_level = dir_q ? level_q : pin_sync;
endmodule // gpg_line
`default_nettype wire

/* dv/gpg_board.sv */
// Board model: four lines, each with a weak driver on the board.
// Assumes pin_oe high means the device drives the line.
`timescale 1ns/10ps
`default_nettype none
module gpg_board (
    // Device drive
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    // Level the board pulls each line to
    input wire logic [3:0] board_lvl,
    // Resolved line level back to the device
    output logic [3:0] pin_in
);
    // Weak board drivers lose wherever the device drives the line
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_lvl);
endmodule // gpg_board
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the general-purpose pin group.
// Assumes the board model on the pins and a one-cycle strobe master.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] board_lvl = 4'h0;
    logic [31:0] seed = 32'h98de4735;
    int mismatches = 0;
    int comparisons = 0;
    int dir_m = 0;
    int lev_m = 0;

    always #25 sys_clk = ~sys_clk;

    gpg_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));
    gpg_board i_board (.pin_out(pin_out), .pin_oe(pin_oe),
        .board_lvl(board_lvl), .pin_in(pin_in));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic test_done();
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        if (a == 16'h4102) begin
            dir_m = d[7:4];
            lev_m = d[3:0];
        end
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    initial begin
        logic [7:0] d;
        logic [15:0] a;
        logic [3:0] dv;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(16'h4102, d);
        chk(d, 8'h00);
        chk({pin_oe, pin_out}, 8'h00);
        for (int i = 0; i < 300; i++) begin
            seed = xs(seed);
            @(posedge sys_clk);
            board_lvl <= seed[11:8];
            // Mostly the mapped register, now and then a stray address
            a = (seed[14:12] == 3'h0) ? seed[31:16] : 16'h4102;
            wr(a, seed[7:0]);
            chk({4'h0, pin_oe}, 8'(dir_m));
            chk({4'h0, pin_out}, 8'(lev_m));
            // A line just turned to input shows the board level only after
            // both synchroniser stages have refilled, so wait one more edge
            @(posedge sys_clk);
            rd(16'h4102, d);
            dv = 4'(dir_m);
            chk(d, {dv, (dv & 4'(lev_m)) | (~dv & board_lvl)});
            @(posedge sys_clk);
            #1 chk(reg_rdata, 8'h00);
            if (a != 16'h4102) begin
                rd(a, d);
                chk(d, 8'h00);
            end
        end
        test_done();
    end

    initial begin
        #(50 * 10000);
        mismatches++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
